/* design/rbm_regs.vh */
// Register map, field positions and timing constants of the buffer model
`ifndef RBM_REGS_VH
`define RBM_REGS_VH
`define RBM_ADDR_W        6
`define RBM_OFF_CTRL      6'h00
`define RBM_OFF_BPP       6'h04
`define RBM_OFF_WIDTH     6'h08
`define RBM_OFF_HEIGHT    6'h0C
`define RBM_OFF_DELAY     6'h10
`define RBM_OFF_CAP       6'h14
`define RBM_OFF_SLBITS    6'h18
`define RBM_OFF_STATUS    6'h1C
`define RBM_OFF_FILL      6'h20
`define RBM_OFF_ERR_GT    6'h24
`define RBM_OFF_ERR_SLICE 6'h28
`define RBM_OFF_GT        6'h2C
`define RBM_CTRL_START    0
`define RBM_CTRL_VBR      1
`define RBM_ST_OVF        0
`define RBM_ST_UNF        1
`define RBM_ST_DONE       2
`define RBM_ST_STATE_LO   4
`define RBM_BPP_W         10
`define RBM_FRAC_W        4
`define RBM_FRAC_ROUND    10'h00F
`define RBM_DIM_W         16
`define RBM_BITS_W        32
`define RBM_GRP_W         16
`define RBM_GT_W          24
`define RBM_SLC_W         16
`define RBM_GROUP_PIX     16'h0003
`define RBM_PIXEL_TIME_NS 100
`define RBM_PIX_PER_GROUP 3
`define RBM_RESP_OKAY     2'b00
`define RBM_RESP_SLVERR   2'b10
`define RBM_RST_BPP       10'h080
`define RBM_RST_WIDTH     16'h0000
`define RBM_RST_HEIGHT    16'h0000
`define RBM_RST_DELAY     16'h0000
`define RBM_RST_CAP       32'h00000000
`define RBM_RST_SLBITS    32'h00000000
`endif

/* design/rbm_top.v */
// Reference decoder buffer model with AXI4-Lite register access
// Operation
// - Fill and drain are evaluated once per group time, one group each.
// - Input enters from slice start to its last bit, pixels times rate.
// - A group is three pixels, the last group of a line may be one or two.
// - Input is truncated to whole bits and the fraction carried forward.
// - During the start-up delay bits enter and none are removed.
// - A fractional delay rounds up to groups and adds ceil(2*rate) bits.
// - After the delay each group time removes one group's coded bits.
// - Once all slice bits are in, input stops while decoding goes on.
// - After the last group, leftover zero stuffing bits are flushed.
// - Variable-rate schedule applies only when its switch is set to one.
// - Variable rate caps each group time's input at the free space.
// - Substream multiplexing is ignored and adds no buffering.
`timescale 1ns/1ns
`include "rbm_regs.vh"
module rbm_top #(
  parameter CLK_PERIOD_NS = 100,
  parameter GT_CYCLES     = (`RBM_PIX_PER_GROUP * `RBM_PIXEL_TIME_NS
                             + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
  input  wire                     aclk,
  input  wire                     aresetn,
  input  wire                     s_axi_awvalid,
  output reg                      s_axi_awready,
  input  wire [`RBM_ADDR_W-1:0]   s_axi_awaddr,
  input  wire                     s_axi_wvalid,
  output reg                      s_axi_wready,
  input  wire [31:0]              s_axi_wdata,
  input  wire [3:0]               s_axi_wstrb,
  output reg                      s_axi_bvalid,
  input  wire                     s_axi_bready,
  output reg  [1:0]               s_axi_bresp,
  input  wire                     s_axi_arvalid,
  output reg                      s_axi_arready,
  input  wire [`RBM_ADDR_W-1:0]   s_axi_araddr,
  output reg                      s_axi_rvalid,
  input  wire                     s_axi_rready,
  output reg  [31:0]              s_axi_rdata,
  output reg  [1:0]               s_axi_rresp,
  input  wire                     grp_valid,
  input  wire [`RBM_GRP_W-1:0]    grp_bits,
  output reg                      grp_take,
  output reg                      slice_done
);
  localparam ST_IDLE  = 2'b00;
  localparam ST_DELAY = 2'b01;
  localparam ST_RUN   = 2'b10;
  localparam ST_DONE  = 2'b11;
  localparam [15:0] GT_LAST = GT_CYCLES - 1;

  reg [1:0]               state_q;
  reg [15:0]              div_q;
  reg                     gt_tick_q;
  reg                     vbr_q;
  reg [`RBM_BPP_W-1:0]    bpp_q;
  reg [`RBM_DIM_W-1:0]    width_q;
  reg [`RBM_DIM_W-1:0]    height_q;
  reg [`RBM_DIM_W-1:0]    delay_q;
  reg [`RBM_BITS_W-1:0]   cap_q;
  reg [`RBM_BITS_W-1:0]   slbits_q;
  reg [`RBM_BITS_W-1:0]   fill_q;
  reg [`RBM_BITS_W-1:0]   rx_q;
  reg [`RBM_FRAC_W-1:0]   carry_q;
  reg [`RBM_GT_W-1:0]     gt_q;
  reg [`RBM_SLC_W-1:0]    slice_q;
  reg [`RBM_DIM_W-1:0]    lpos_q;
  reg [`RBM_DIM_W-1:0]    dpos_q;
  reg [`RBM_DIM_W-1:0]    dline_q;
  reg [`RBM_DIM_W-1:0]    dly_pix_q;
  reg                     dly_frac_q;
  reg                     ovf_q;
  reg                     unf_q;
  reg [`RBM_GT_W-1:0]     err_gt_q;
  reg [`RBM_SLC_W-1:0]    err_slice_q;
  reg                     aw_have_q;
  reg                     w_have_q;
  reg [`RBM_ADDR_W-1:0]   awaddr_q;
  reg [31:0]              wdata_q;
  reg [3:0]               wstrb_q;

  // Pixels of the group starting at line position pos
  function [1:0] grp_pix;
    input [`RBM_DIM_W-1:0] wid;
    input [`RBM_DIM_W-1:0] pos;
    reg   [`RBM_DIM_W-1:0] left;
    begin
      left = wid - pos;
      if (left < `RBM_GROUP_PIX)
        grp_pix = left[1:0];
      else
        grp_pix = 2'd3;
    end
  endfunction

  // Next line position, wrapping after the short or full last group
  function [`RBM_DIM_W-1:0] next_pos;
    input [`RBM_DIM_W-1:0] wid;
    input [`RBM_DIM_W-1:0] pos;
    begin
      if (wid - pos <= `RBM_GROUP_PIX)
        next_pos = {`RBM_DIM_W{1'b0}};
      else
        next_pos = pos + `RBM_GROUP_PIX;
    end
  endfunction

  function mapped;
    input [`RBM_ADDR_W-1:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `RBM_OFF_GT);
    end
  endfunction

  // Model datapath, all evaluated for the current group time
  reg  [1:0]              npix;
  reg  [12:0]             acc;
  reg  [`RBM_BITS_W-1:0]  in_nom;
  reg  [`RBM_BITS_W-1:0]  in_bits;
  reg  [`RBM_BITS_W-1:0]  left_bits;
  reg  [`RBM_BITS_W-1:0]  eff_cap;
  reg  [`RBM_BITS_W-1:0]  space;
  reg  [`RBM_BITS_W:0]    sum;
  reg  [`RBM_BITS_W:0]    rm;
  reg  [11:0]             extra;
  reg                     removing;
  reg                     last_grp;
  always @*
  begin
    npix = grp_pix(width_q, lpos_q);
    acc = {11'd0, npix} * {3'd0, bpp_q} + {9'd0, carry_q};
    left_bits = slbits_q - rx_q;
    in_nom = {23'd0, acc[12:`RBM_FRAC_W]};
    if (rx_q >= slbits_q)
      in_nom = {`RBM_BITS_W{1'b0}};
    else if (in_nom > left_bits)
      in_nom = left_bits;
    extra = ({1'b0, bpp_q, 1'b0} + {2'b00, `RBM_FRAC_ROUND}) >> `RBM_FRAC_W;
    eff_cap = cap_q + (dly_frac_q ? {20'd0, extra} : 32'd0);
    space = (fill_q < eff_cap) ? eff_cap - fill_q : 32'd0;
    if (vbr_q && in_nom > space)
      in_bits = space;
    else
      in_bits = in_nom;
    sum = {1'b0, fill_q} + {1'b0, in_bits};
    removing = (state_q == ST_RUN);
    rm = removing ? {17'd0, grp_bits} : 33'd0;
    last_grp = (width_q - dpos_q <= `RBM_GROUP_PIX)
               && (dline_q + 16'd1 >= height_q);
  end

  // Group-time divider, the single rate of the model
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_q <= 16'h0000;
      gt_tick_q <= 1'b0;
    end
    else if (div_q >= GT_LAST)
    begin
      div_q <= 16'h0000;
      gt_tick_q <= 1'b1;
    end
    else
    begin
      div_q <= div_q + 16'h0001;
      gt_tick_q <= 1'b0;
    end
  end

  wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  wire start   = wr_fire && awaddr_q == `RBM_OFF_CTRL && wstrb_q[0]
                 && wdata_q[`RBM_CTRL_START];
  wire st_clr  = wr_fire && awaddr_q == `RBM_OFF_STATUS && wstrb_q[0];

  // Buffer model state machine
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_IDLE;
      fill_q <= 32'h00000000;
      rx_q <= 32'h00000000;
      carry_q <= 4'h0;
      gt_q <= 24'h000000;
      slice_q <= 16'h0000;
      lpos_q <= 16'h0000;
      dpos_q <= 16'h0000;
      dline_q <= 16'h0000;
      dly_pix_q <= 16'h0000;
      dly_frac_q <= 1'b0;
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      err_gt_q <= 24'h000000;
      err_slice_q <= 16'h0000;
      grp_take <= 1'b0;
      slice_done <= 1'b0;
    end
    else
    begin
      grp_take <= 1'b0;
      if (st_clr)
      begin
        ovf_q <= ovf_q & ~wdata_q[`RBM_ST_OVF];
        unf_q <= unf_q & ~wdata_q[`RBM_ST_UNF];
      end
      if (start)
      begin
        fill_q <= 32'h00000000;
        carry_q <= 4'h0;
        gt_q <= 24'h000000;
        rx_q <= 32'h00000000;
        lpos_q <= 16'h0000;
        dpos_q <= 16'h0000;
        dline_q <= 16'h0000;
        dly_pix_q <= 16'h0000;
        // Reserve known at start, so it also covers the delay itself
        dly_frac_q <= (delay_q % `RBM_PIX_PER_GROUP != 0);
        slice_q <= slice_q + 16'h0001;
        slice_done <= 1'b0;
        state_q <= (delay_q == 16'h0000) ? ST_RUN : ST_DELAY;
      end
      else if (gt_tick_q)
      begin
        // One shared buffer per slice; no multiplexing reserve
        case (state_q)
          ST_DELAY, ST_RUN:
          begin
            gt_q <= gt_q + 24'h000001;
            rx_q <= rx_q + in_bits;
            carry_q <= acc[`RBM_FRAC_W-1:0];
            lpos_q <= next_pos(width_q, lpos_q);
            if (!vbr_q && sum > {1'b0, eff_cap})
            begin
              ovf_q <= 1'b1;
              err_gt_q <= gt_q;
              err_slice_q <= slice_q;
            end
            if (removing && (!grp_valid || sum < rm))
            begin
              unf_q <= 1'b1;
              err_gt_q <= gt_q;
              err_slice_q <= slice_q;
            end
            if (state_q == ST_DELAY)
            begin
              fill_q <= sum[`RBM_BITS_W-1:0];
              dly_pix_q <= dly_pix_q + `RBM_GROUP_PIX;
              if (dly_pix_q + `RBM_GROUP_PIX >= delay_q)
              begin
                state_q <= ST_RUN;
              end
            end
            else
            begin
              // Underflow clamps at empty so later checks stay meaningful
              fill_q <= (sum < rm) ? 32'h00000000
                        : sum[`RBM_BITS_W-1:0] - rm[`RBM_BITS_W-1:0];
              grp_take <= grp_valid;
              dpos_q <= next_pos(width_q, dpos_q);
              if (width_q - dpos_q <= `RBM_GROUP_PIX)
                dline_q <= dline_q + 16'h0001;
              if (last_grp)
              begin
                fill_q <= 32'h00000000;
                slice_done <= 1'b1;
                state_q <= ST_DONE;
              end
            end
          end
          default:
          begin
            state_q <= state_q;
          end
        endcase
      end
    end
  end

  // AXI4-Lite slave, address and data taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RBM_RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= {`RBM_ADDR_W{1'b0}};
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      vbr_q <= 1'b0;
      bpp_q <= `RBM_RST_BPP;
      width_q <= `RBM_RST_WIDTH;
      height_q <= `RBM_RST_HEIGHT;
      delay_q <= `RBM_RST_DELAY;
      cap_q <= `RBM_RST_CAP;
      slbits_q <= `RBM_RST_SLBITS;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_q) ? `RBM_RESP_OKAY
                       : `RBM_RESP_SLVERR;
        // Strobe of byte lane 0 alone enables each write; the whole field is taken
        if (awaddr_q == `RBM_OFF_CTRL && wstrb_q[0])
          vbr_q <= wdata_q[`RBM_CTRL_VBR];
        if (awaddr_q == `RBM_OFF_BPP && wstrb_q[0])
          bpp_q <= wdata_q[`RBM_BPP_W-1:0];
        if (awaddr_q == `RBM_OFF_WIDTH && wstrb_q[0])
          width_q <= wdata_q[`RBM_DIM_W-1:0];
        if (awaddr_q == `RBM_OFF_HEIGHT && wstrb_q[0])
          height_q <= wdata_q[`RBM_DIM_W-1:0];
        if (awaddr_q == `RBM_OFF_DELAY && wstrb_q[0])
          delay_q <= wdata_q[`RBM_DIM_W-1:0];
        if (awaddr_q == `RBM_OFF_CAP && wstrb_q[0])
          cap_q <= wdata_q;
        if (awaddr_q == `RBM_OFF_SLBITS && wstrb_q[0])
          slbits_q <= wdata_q;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RBM_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? `RBM_RESP_OKAY
                     : `RBM_RESP_SLVERR;
      case (s_axi_araddr)
        `RBM_OFF_CTRL:      s_axi_rdata <= {30'd0, vbr_q, 1'b0};
        `RBM_OFF_BPP:       s_axi_rdata <= {22'd0, bpp_q};
        `RBM_OFF_WIDTH:     s_axi_rdata <= {16'd0, width_q};
        `RBM_OFF_HEIGHT:    s_axi_rdata <= {16'd0, height_q};
        `RBM_OFF_DELAY:     s_axi_rdata <= {16'd0, delay_q};
        `RBM_OFF_CAP:       s_axi_rdata <= cap_q;
        `RBM_OFF_SLBITS:    s_axi_rdata <= slbits_q;
        `RBM_OFF_STATUS:    s_axi_rdata <= {26'd0, state_q, 1'b0,
                                            slice_done, unf_q, ovf_q};
        `RBM_OFF_FILL:      s_axi_rdata <= fill_q;
        `RBM_OFF_ERR_GT:    s_axi_rdata <= {8'd0, err_gt_q};
        `RBM_OFF_ERR_SLICE: s_axi_rdata <= {16'd0, err_slice_q};
        `RBM_OFF_GT:        s_axi_rdata <= {8'd0, gt_q};
        default:            s_axi_rdata <= 32'h00000000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // rbm_top

/* bench/rbm_monitor.sv */
// Assertion checker for the buffer model ports
`timescale 1ns/1ns
module rbm_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        grp_valid,
  input wire logic        grp_take,
  input wire logic        slice_done
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  // Spacing of two idle cycles assumes a three-cycle group time
  chk_take_spacing: assert property (grp_take |=> !grp_take [*2])
    else $error("group removals closer than one group time");
  chk_take_cause: assert property (grp_take |-> $past(grp_valid))
    else $error("group removed without a presented size");
  chk_done_quiet: assert property (slice_done |=> !grp_take)
    else $error("group removed after the slice ended");
  chk_done_sticky: assert property (
    slice_done |=> slice_done || $rose(s_axi_bvalid))
    else $error("slice end flag dropped without a new start");
  chk_write_resp: assert property (wr_taken |=> wr_answer)
    else $error("write response late or ready not lowered");
  chk_read_resp: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not returned one cycle after address");
  chk_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held until accepted");
  chk_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held until accepted");
endmodule // rbm_monitor
bind rbm_top rbm_monitor i_mon (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .grp_valid, .grp_take, .slice_done
);

/* bench/rbm_src_model.sv */
// Coded-group source at the far side of the buffer model
`timescale 1ns/1ns
module rbm_src_model (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        grp_load,
  input wire logic        grp_hold,
  input wire logic [15:0] grp_first,
  input wire logic [15:0] grp_step,
  input wire logic        grp_take,
  output logic            grp_valid,
  output logic [15:0]     grp_bits
);
  logic [15:0] size_q;
  logic [15:0] junk_q;
  // Changing filler so a withheld size is never mistaken for a real one
  always @(posedge aclk)
  begin
    junk_q <= ~junk_q;
    if (!aresetn)
    begin
      size_q <= 16'h0000;
      junk_q <= 16'h5A5A;
    end
    else if (grp_load)
      size_q <= grp_first;
    else if (grp_take)
      size_q <= size_q + grp_step;
  end
  assign grp_valid = aresetn && !grp_hold;
  assign grp_bits = grp_valid ? size_q : junk_q;
endmodule // rbm_src_model

/* bench/rbm_tb_top.sv */
// Self-checking bench for the buffer model
`timescale 1ns/1ns
`include "rbm_regs.vh"
module rbm_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic grp_load = 1'b0, grp_hold = 1'b0;
  logic [15:0] grp_first = 16'h0, grp_step = 16'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, grp_valid, grp_take, slice_done;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] grp_bits;
  int n_fail = 0, checks_done = 0, takes = 0, i;
  logic [31:0] rd;
  logic [1:0] rs;
  rbm_top i_dut (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .grp_valid, .grp_bits, .grp_take,
    .slice_done
  );
  rbm_src_model i_src (
    .aclk, .aresetn, .grp_load, .grp_hold, .grp_first, .grp_step,
    .grp_take, .grp_valid, .grp_bits
  );
  always #50 aclk = ~aclk;
  always @(posedge aclk)
    takes <= grp_load ? 0 : takes + (grp_take === 1'b1);
  function automatic logic [31:0] n_grp(input logic [15:0] w, h);
    return h * ((w + 16'h2) / 16'h3);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Ready for the answer is raised late at random to stall the slave
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic [1:0] r);
    int k;
    int dly;
    dly = $urandom_range(2);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    for (k = 0; k < 64; k++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (wr ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready)
      begin
        q = s_axi_rdata;
        r = wr ? s_axi_bresp : s_axi_rresp;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        return;
      end
      if (k >= dly)
      begin
        s_axi_bready <= wr;
        s_axi_rready <= !wr;
      end
    end
    n_fail++;
    finish_test();
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd, rs);
    check({30'h0, rs}, {30'h0, `RBM_RESP_OKAY});
  endtask
  task automatic rdx(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rd, rs);
    check(rd, e);
  endtask
  task automatic run(input logic vbr, input logic [15:0] w, h, bpp, dl,
                     input logic [31:0] cap, sl, input logic [15:0] f, s,
                     input logic hl, input logic [31:0] est);
    int k;
    wr(`RBM_OFF_BPP, {16'h0, bpp});
    wr(`RBM_OFF_WIDTH, {16'h0, w});
    wr(`RBM_OFF_HEIGHT, {16'h0, h});
    wr(`RBM_OFF_DELAY, {16'h0, dl});
    wr(`RBM_OFF_CAP, cap);
    wr(`RBM_OFF_SLBITS, sl);
    grp_first <= f;
    grp_step <= s;
    grp_hold <= hl;
    grp_load <= 1'b1;
    @(posedge aclk);
    grp_load <= 1'b0;
    wr(`RBM_OFF_CTRL, {30'h0, vbr, 1'b1});
    for (k = 0; k < 2000 && slice_done !== 1'b1; k++)
    begin
      @(posedge aclk);
      if (k == 30)
        grp_hold <= 1'b0;
    end
    if (slice_done !== 1'b1)
    begin
      n_fail++;
      finish_test();
    end
    rdx(`RBM_OFF_STATUS, est);
    rdx(`RBM_OFF_FILL, 32'h0);
    if (!hl)
      check(takes, n_grp(w, h));
    wr(`RBM_OFF_STATUS, 32'h3);
  endtask
  initial
  begin
    void'($urandom(32'h65DE));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 12; i++)
      rdx(6'(i * 4), i == 1 ? {22'h0, `RBM_RST_BPP} : 32'h0);
    bus(1'b0, 6'h02, 32'h0, rd, rs);
    check(rd, 32'h0);
    check({30'h0, rs}, {30'h0, `RBM_RESP_SLVERR});
    bus(1'b1, 6'h3C, 32'hFFFFFFFF, rd, rs);
    check({30'h0, rs}, {30'h0, `RBM_RESP_SLVERR});
    run(0, 7, 1, 16'h080, 0, 24, 1000, 24, 16'hFFF8, 0, 32'h34);
    run(0, 6, 1, 16'h088, 0, 1000, 1000, 25, 1, 0, 32'h34);
    run(0, 6, 1, 16'h080, 4, 40, 48, 24, 0, 0, 32'h34);
    run(1, 6, 1, 16'h080, 4, 30, 1000, 24, 0, 0, 32'h34);
    run(0, 6, 1, 16'h080, 4, 30, 1000, 24, 0, 0, 32'h35);
    rdx(`RBM_OFF_ERR_SLICE, 32'h5);
    run(0, 6, 2, 16'h080, 0, 32'hFFFF, 32'hFFFF, 8, 0, 1, 32'h36);
    rdx(`RBM_OFF_STATUS, 32'h34);
    for (i = 0; i < 3; i++)
      run(0, 16'($urandom_range(20, 3)), 16'($urandom_range(3, 1)),
          16'h080, 0, 32'hFFFF, 32'hFFFF, 16'($urandom_range(8, 1)), 0,
          0, 32'h34);
    finish_test();
  end
endmodule // rbm_tb_top
